// file: rtl/dsifr_pkg.sv
package dsifr_pkg;
   // transport packet
   localparam logic [7:0] PKT_LAST     = 8'hBB;
   localparam logic [7:0] SYNC_BYTE    = 8'h47;
   localparam logic       TEI_VAL      = 1'b0;
   localparam logic       PUSI_VAL     = 1'b1;
   localparam logic       PRIO_VAL     = 1'b0;
   localparam logic [1:0] SCRAMBLE_VAL = 2'b00;
   localparam logic [1:0] AFC_VAL      = 2'b01;
   localparam logic [7:0] POINTER_VAL  = 8'h00;
   localparam logic [3:0] CC_RESET     = 4'h0;
   // section header
   localparam logic [7:0] TABLE_ID     = 8'h3B;
   localparam logic       SSI_VAL      = 1'b0;
   localparam logic [1:0] RSV2         = 2'b11;
   localparam logic [4:0] VERSION_VAL  = 5'h00;
   localparam logic       CUR_NEXT_VAL = 1'b1;
   localparam logic [7:0] SECNUM_VAL   = 8'h00;
   localparam logic [7:0] RSV8         = 8'hFF;
   localparam logic [7:0] STUFF_BYTE   = 8'hFF;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;
   // message header
   localparam logic [7:0]  PROTO_DISC  = 8'h11;
   localparam logic [7:0]  DSMCC_TYPE  = 8'h03;
   localparam logic [15:0] MSG_ID      = 16'h1006;
   localparam logic [1:0]  ORIGINATOR  = 2'b10;
   localparam logic [7:0]  ADAPT_LEN   = 8'h00;
   localparam logic [31:0] CHECKSUM    = 32'h00000000;
   // byte positions inside the packet
   localparam logic [7:0] POS_HDR1     = 8'h01;
   localparam logic [7:0] POS_PID_LO   = 8'h02;
   localparam logic [7:0] POS_HDR3     = 8'h03;
   localparam logic [7:0] POS_PTR      = 8'h04;
   localparam logic [7:0] POS_TBL      = 8'h05;
   localparam logic [7:0] POS_SLEN_HI  = 8'h06;
   localparam logic [7:0] POS_VER      = 8'h0A;
   localparam logic [7:0] POS_TID      = 8'h11;
   localparam logic [7:0] POS_SRV      = 8'h19;
   localparam logic [7:0] POS_SRV_END  = 8'h2C;
   localparam logic [7:0] POS_GROUPS   = 8'h33;
   localparam logic [7:0] SRV_BYTES    = 8'h14;
   // length arithmetic, per group twelve bytes
   localparam int GRP_BYTES = 12;
   localparam int PDL_BASE  = 4;
   localparam int MSG_BASE  = 24;
   localparam int SEC_BASE  = 21;
   localparam int SEC_MAX   = 4093;
   localparam int NG_MAX    = 10;
endpackage : dsifr_pkg

// file: rtl/dsifr_framer.sv
`timescale 1ns/1ps
// Overview of operation
// (RQ1) start flag set in DSI packet
// (RQ2) one configurable 13-bit packet identifier
// (RQ3) payload only, not scrambled
// (RQ4) zero pointer byte before section
// (RQ5) table id marks server initiate section
// (RQ6) syntax flag cleared, checksum follows
// (RQ7) private bit inverse of syntax flag
// (RQ8) all reserved bits driven to one
// (RQ9) section length counted, within maximum
// (RQ10) table extension from low transaction bytes
// (RQ11) version number all zeros
// (RQ12) current flag set to one
// (RQ13) section numbers both zero
// (RQ14) transaction id subfields, originator binary 10
// (RQ15) adaptation length zero
// (RQ16) message length excludes integrity field
// (RQ17) server id twenty all-ones bytes
// (RQ18) private length covers group structure
// (RQ19) group id is its DII transaction id
// (RQ20) group size sums module sizes
// (RQ21) group descriptor lengths zero
// (RQ22) zero integrity value means no checksum
// (RQ23) continuity counter increments, wraps
// (RQ24) leftover payload stuffed with all ones
// (RQ25) start packets carry pointer byte
// (RQ26) protocol, type and message id fixed
// (RQ27) sync byte, error and priority cleared
module dsifr_framer #(
   parameter int NG = 2
) (
   // clock, reset, enable
   input  wire logic           CLOCK_I,
   input  wire logic           ARST_N_I,
   input  wire logic           CE_I,
   // request and message fields
   input  wire logic           START_I,
   input  wire logic [12:0]    PID_I,
   input  wire logic [13:0]    TID_VERSION_I,
   input  wire logic [14:0]    TID_IDENT_I,
   input  wire logic           TID_UPDATED_I,
   input  wire logic [NG*32-1:0] GROUP_ID_I,
   input  wire logic [NG*32-1:0] GROUP_SIZE_I,
   // byte stream to multiplexer
   input  wire logic           TS_READY_I,
   output logic [7:0]          TS_DATA_O,
   output logic                TS_VALID_O,
   output logic                TS_SOP_O,
   output logic                TS_EOP_O,
   output logic                BUSY_O
);

   typedef enum logic [1:0] {
      DSIFR_IDLE = 2'b01,
      DSIFR_SEND = 2'b10
   } dsifr_state_t;

   // lengths fixed by the group count; NG above NG_MAX overruns one packet
   localparam int PDL_I = dsifr_pkg::PDL_BASE + dsifr_pkg::GRP_BYTES * NG;
   localparam int MSG_I = dsifr_pkg::MSG_BASE + PDL_I;
   localparam int SEC_I = dsifr_pkg::SEC_BASE + MSG_I;
   localparam logic [15:0] PDL     = 16'(PDL_I);                     // see RQ18
   localparam logic [15:0] MSG_LEN = 16'(MSG_I);                     // see RQ16
   localparam logic [11:0] SEC_LEN = 12'(SEC_I);                     // see RQ9
   localparam logic [15:0] NGROUPS = 16'(NG);
   localparam logic [7:0]  GEND    = 8'(dsifr_pkg::POS_GROUPS + dsifr_pkg::GRP_BYTES * NG);
   localparam logic [7:0]  STUFF_AT = 8'(GEND + 8'h06);

   dsifr_state_t       state_reg, state_next;
   logic [7:0]         idx_reg, idx_next;
   logic [3:0]         cc_reg, cc_next;
   logic [12:0]        pid_reg, pid_next;
   logic [31:0]        tid_reg, tid_next;
   logic [NG*32-1:0]   gid_reg, gid_next;
   logic [NG*32-1:0]   gsz_reg, gsz_next;
   logic [7:0]         data_reg, data_next;
   logic [7:0]         oidx_reg, oidx_next;
   logic               valid_reg, valid_next;
   logic               sop_reg, sop_next;
   logic               eop_reg, eop_next;
   logic               busy_reg, busy_next;
   logic               adv;

   function automatic logic [7:0] grp_byte(
      input logic [7:0]       i,
      input logic [NG*32-1:0] gid,
      input logic [NG*32-1:0] gsz
   );
      logic [7:0]  r;
      logic [7:0]  off;
      logic [31:0] w;
      r = dsifr_pkg::ZERO_BYTE;
      for (int g = 0; g < NG; g++) begin
         off = 8'(i - dsifr_pkg::POS_GROUPS - 8'(g * dsifr_pkg::GRP_BYTES));
         if (i >= 8'(dsifr_pkg::POS_GROUPS + g * dsifr_pkg::GRP_BYTES) &&
             off < 8'(dsifr_pkg::GRP_BYTES)) begin
            // descriptor lengths stay zero: no descriptors carried
            if (off < 8'h04) begin
               w = gid[g*32 +: 32];                                  // see RQ19
               r = w[8'(31 - 8 * off) -: 8];
            end else if (off < 8'h08) begin
               w = gsz[g*32 +: 32];                                  // see RQ20
               r = w[8'(63 - 8 * off) -: 8];
            end else begin
               r = dsifr_pkg::ZERO_BYTE;                             // see RQ21
            end
         end
      end
      return r;
   endfunction : grp_byte

   function automatic logic [7:0] frame_byte(
      input logic [7:0]       i,
      input logic [12:0]      pid,
      input logic [3:0]       cc,
      input logic [31:0]      tid,
      input logic [NG*32-1:0] gid,
      input logic [NG*32-1:0] gsz
   );
      logic [7:0] r;
      r = dsifr_pkg::STUFF_BYTE;                                     // see RQ24
      case (i)
         8'h00: r = dsifr_pkg::SYNC_BYTE;                            // see RQ27
         8'h01: r = {dsifr_pkg::TEI_VAL, dsifr_pkg::PUSI_VAL,
                     dsifr_pkg::PRIO_VAL, pid[12:8]};                // see RQ1
         8'h02: r = pid[7:0];                                        // see RQ2
         8'h03: r = {dsifr_pkg::SCRAMBLE_VAL, dsifr_pkg::AFC_VAL, cc}; // see RQ3
         8'h04: r = dsifr_pkg::POINTER_VAL;                          // see RQ4 RQ25
         8'h05: r = dsifr_pkg::TABLE_ID;                             // see RQ5
         8'h06: r = {dsifr_pkg::SSI_VAL, ~dsifr_pkg::SSI_VAL,
                     dsifr_pkg::RSV2, SEC_LEN[11:8]};                // see RQ6 RQ7 RQ8
         8'h07: r = SEC_LEN[7:0];                                    // see RQ9
         8'h08: r = tid[15:8];                                       // see RQ10
         8'h09: r = tid[7:0];                                        // see RQ10
         8'h0A: r = {dsifr_pkg::RSV2, dsifr_pkg::VERSION_VAL,
                     dsifr_pkg::CUR_NEXT_VAL};                       // see RQ8 RQ11 RQ12
         8'h0B: r = dsifr_pkg::SECNUM_VAL;                           // see RQ13
         8'h0C: r = dsifr_pkg::SECNUM_VAL;                           // see RQ13
         8'h0D: r = dsifr_pkg::PROTO_DISC;                           // see RQ26
         8'h0E: r = dsifr_pkg::DSMCC_TYPE;                           // see RQ26
         8'h0F: r = dsifr_pkg::MSG_ID[15:8];                         // see RQ26
         8'h10: r = dsifr_pkg::MSG_ID[7:0];                          // see RQ26
         8'h11: r = tid[31:24];                                      // see RQ14
         8'h12: r = tid[23:16];
         8'h13: r = tid[15:8];
         8'h14: r = tid[7:0];
         8'h15: r = dsifr_pkg::RSV8;                                 // see RQ8
         8'h16: r = dsifr_pkg::ADAPT_LEN;                            // see RQ15
         8'h17: r = MSG_LEN[15:8];                                   // see RQ16
         8'h18: r = MSG_LEN[7:0];
         8'h2D: r = dsifr_pkg::ZERO_BYTE;
         8'h2E: r = dsifr_pkg::ZERO_BYTE;
         8'h2F: r = PDL[15:8];                                       // see RQ18
         8'h30: r = PDL[7:0];
         8'h31: r = NGROUPS[15:8];
         8'h32: r = NGROUPS[7:0];
         default: begin
            if (i >= dsifr_pkg::POS_SRV && i <= dsifr_pkg::POS_SRV_END) begin
               r = dsifr_pkg::RSV8;                                  // see RQ17
            end else if (i >= dsifr_pkg::POS_GROUPS && i < GEND) begin
               r = grp_byte(i, gid, gsz);
            end else if (i >= GEND && i < GEND + 8'h02) begin
               r = dsifr_pkg::ZERO_BYTE;
            end else if (i >= GEND + 8'h02 && i < STUFF_AT) begin
               // zero integrity value: receivers skip verification
               r = dsifr_pkg::CHECKSUM[8'(31 - 8 * (i - GEND - 8'h02)) -: 8]; // see RQ22
            end else begin
               r = dsifr_pkg::STUFF_BYTE;                            // see RQ24
            end
         end
      endcase
      return r;
   endfunction : frame_byte

   // output stage moves only when empty or drained, so a stalled sink holds the byte
   assign adv = !valid_reg || TS_READY_I;

   always_comb begin
      state_next = state_reg;
      idx_next   = idx_reg;
      cc_next    = cc_reg;
      pid_next   = pid_reg;
      tid_next   = tid_reg;
      gid_next   = gid_reg;
      gsz_next   = gsz_reg;
      data_next  = data_reg;
      oidx_next  = oidx_reg;
      valid_next = valid_reg;
      sop_next   = sop_reg;
      eop_next   = eop_reg;
      case (state_reg)
         DSIFR_IDLE: begin
            if (adv) begin
               valid_next = 1'b0;
               sop_next   = 1'b0;
               eop_next   = 1'b0;
            end
            if (START_I) begin
               // fields latched so the source may change them mid-packet
               pid_next   = PID_I;                                   // see RQ2
               tid_next   = {dsifr_pkg::ORIGINATOR, TID_VERSION_I,
                             TID_IDENT_I, TID_UPDATED_I};            // see RQ14
               gid_next   = GROUP_ID_I;
               gsz_next   = GROUP_SIZE_I;
               idx_next   = 8'h00;
               state_next = DSIFR_SEND;
            end
         end
         DSIFR_SEND: begin
            if (adv) begin
               data_next  = frame_byte(idx_reg, pid_reg, cc_reg, tid_reg, gid_reg, gsz_reg);
               oidx_next  = idx_reg;
               valid_next = 1'b1;
               sop_next   = (idx_reg == 8'h00);
               eop_next   = (idx_reg == dsifr_pkg::PKT_LAST);
               idx_next   = 8'(idx_reg + 8'h01);
               if (idx_reg == dsifr_pkg::PKT_LAST) begin
                  cc_next    = 4'(cc_reg + 4'h1);                    // see RQ23
                  state_next = DSIFR_IDLE;
               end
            end
         end
         default: begin
            state_next = DSIFR_IDLE;
         end
      endcase
      busy_next = (state_next == DSIFR_SEND);
   end

   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_reg <= DSIFR_IDLE;
         idx_reg   <= 8'h00;
         cc_reg    <= dsifr_pkg::CC_RESET;
         pid_reg   <= 13'h0000;
         tid_reg   <= 32'h00000000;
         gid_reg   <= '0;
         gsz_reg   <= '0;
         data_reg  <= 8'h00;
         oidx_reg  <= 8'h00;
         valid_reg <= 1'b0;
         sop_reg   <= 1'b0;
         eop_reg   <= 1'b0;
         busy_reg  <= 1'b0;
      end else if (CE_I) begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
         cc_reg    <= cc_next;
         pid_reg   <= pid_next;
         tid_reg   <= tid_next;
         gid_reg   <= gid_next;
         gsz_reg   <= gsz_next;
         data_reg  <= data_next;
         oidx_reg  <= oidx_next;
         valid_reg <= valid_next;
         sop_reg   <= sop_next;
         eop_reg   <= eop_next;
         busy_reg  <= busy_next;
      end
   end

   assign TS_DATA_O  = data_reg;
   assign TS_VALID_O = valid_reg;
   assign TS_SOP_O   = sop_reg;
   assign TS_EOP_O   = eop_reg;
   assign BUSY_O     = busy_reg;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!ARST_N_I);

   property p_sync;
      valid_reg && oidx_reg == 8'h00 |-> data_reg == 8'h47 && sop_reg;
   endproperty
   a_sync: assert property (p_sync) else $error("bad sync byte"); // see RQ27

   property p_pusi;
      valid_reg && oidx_reg == 8'h01 |-> data_reg[7:5] == 3'b010 && data_reg[4:0] == pid_reg[12:8];
   endproperty
   a_pusi: assert property (p_pusi) else $error("bad header byte one"); // see RQ1

   property p_pid;
      valid_reg && oidx_reg == 8'h02 |-> data_reg == pid_reg[7:0];
   endproperty
   a_pid: assert property (p_pid) else $error("bad packet id"); // see RQ2

   property p_afc;
      valid_reg && oidx_reg == 8'h03 |-> data_reg[7:4] == 4'h1 && data_reg[3:0] == cc_reg;
   endproperty
   a_afc: assert property (p_afc) else $error("bad control nibble"); // see RQ3

   property p_ptr;
      valid_reg && oidx_reg == 8'h04 |-> data_reg == 8'h00;
   endproperty
   a_ptr: assert property (p_ptr) else $error("bad pointer byte"); // see RQ4 RQ25

   property p_tbl;
      valid_reg && oidx_reg == 8'h05 |-> data_reg == 8'h3B;
   endproperty
   a_tbl: assert property (p_tbl) else $error("bad table id"); // see RQ5

   property p_flags;
      valid_reg && oidx_reg == 8'h06 |-> data_reg[7:4] == 4'h7;
   endproperty
   a_flags: assert property (p_flags) else $error("bad section flags"); // see RQ7

   property p_ver;
      valid_reg && oidx_reg == 8'h0A |-> data_reg == 8'hC1;
   endproperty
   a_ver: assert property (p_ver) else $error("bad version byte"); // see RQ11

   property p_cc;
      state_reg == DSIFR_SEND && adv && CE_I && idx_reg == dsifr_pkg::PKT_LAST
         |=> cc_reg == 4'($past(cc_reg) + 4'h1);
   endproperty
   a_cc: assert property (p_cc) else $error("counter not stepped"); // see RQ23

   property p_stuff;
      valid_reg && oidx_reg >= STUFF_AT |-> data_reg == 8'hFF;
   endproperty
   a_stuff: assert property (p_stuff) else $error("bad stuffing"); // see RQ24

   property p_hold;
      valid_reg && !TS_READY_I |=> valid_reg && $stable(data_reg) && $stable(oidx_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("byte lost under stall");

endmodule : dsifr_framer

// file: dv/dsifr_sink.sv
`timescale 1ns/1ps
// behavioural multiplexer input: takes bytes, may stall, judges the integrity field
module dsifr_sink (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   // stream from the framer
   input  wire logic [7:0] data_i,
   input  wire logic       valid_i,
   input  wire logic       sop_i,
   input  wire logic       eop_i,
   output logic            ready_o,
   // stall control
   input  wire logic       slow_i
);
   logic [9:0]  got[$];
   logic [1:0]  cnt_reg;
   logic [11:0] slen;
   logic        sum_nz;
   int          pos;
   int          unverified;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= 2'h0;
         ready_o <= 1'h0;
         unverified = 0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         // slow mode is ready one cycle in four, so the framer's output stays stalled three cycles in four
         ready_o <= !slow_i || (cnt_reg == 2'h2);
         if (valid_i && ready_o) begin
            got.push_back({eop_i, sop_i, data_i});
            pos = sop_i ? 0 : pos + 1;
            if (pos == 6)
               slen[11:8] = data_i[3:0];
            if (pos == 7) begin
               slen[7:0] = data_i;
               sum_nz = 1'h0;
            end
            if (pos > 7 && pos + 4 > 7 + slen && pos <= 7 + slen)
               sum_nz = sum_nz | (|data_i);
            // a zero integrity value means nothing to verify
            if (eop_i && !sum_nz)
               unverified++;
         end
      end
   end
endmodule : dsifr_sink

// file: dv/dsifr_framer_bench.sv
`timescale 1ns/1ps
module dsifr_framer_bench;
   logic        clk;
   logic        arst_n;
   logic        ce;
   logic        start;
   logic [12:0] pid;
   logic [13:0] tver;
   logic [14:0] tidn;
   logic        tupd;
   logic [63:0] gid;
   logic [63:0] gsz;
   logic        ready;
   logic [7:0]  data;
   logic        valid;
   logic        sop;
   logic        eop;
   logic        busy;
   logic        slow;
   logic [7:0]  ex[188];
   int          fails;
   int          checks;

   dsifr_framer #(.NG(2)) dsifr_framer_inst (
      .CLOCK_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .START_I(start), .PID_I(pid),
      .TID_VERSION_I(tver), .TID_IDENT_I(tidn), .TID_UPDATED_I(tupd),
      .GROUP_ID_I(gid), .GROUP_SIZE_I(gsz), .TS_READY_I(ready), .TS_DATA_O(data),
      .TS_VALID_O(valid), .TS_SOP_O(sop), .TS_EOP_O(eop), .BUSY_O(busy));

   dsifr_sink dsifr_sink_inst (
      .clk_i(clk), .arst_n_i(arst_n), .data_i(data), .valid_i(valid), .sop_i(sop),
      .eop_i(eop), .ready_o(ready), .slow_i(slow));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [9:0] seen, input logic [9:0] want, input string what);
      checks++;
      if (seen !== want) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, want);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   // expected packet built field by field; lengths follow from where fields land
   task automatic mk(input logic [3:0] cc);
      logic [31:0] tid;
      int          p;
      int          g;
      tid = {2'h2, tver, tidn, tupd};
      for (p = 0; p < 188; p++)
         ex[p] = 8'hFF;
      {ex[0], ex[1], ex[2], ex[3], ex[4], ex[5]} = {8'h47, 3'h2, pid, 4'h1, cc, 16'h003B};
      {ex[8], ex[9], ex[10], ex[11], ex[12]} = {tid[15:0], 8'hC1, 16'h0000};
      {ex[13], ex[14], ex[15], ex[16]} = 32'h11031006;
      {ex[17], ex[18], ex[19], ex[20], ex[21], ex[22]} = {tid, 16'hFF00};
      {ex[45], ex[46], ex[49], ex[50]} = 32'h00000002;
      p = 51;
      for (g = 0; g < 2; g++) begin
         {ex[p], ex[p+1], ex[p+2], ex[p+3]} = gid[g*32+:32];
         {ex[p+4], ex[p+5], ex[p+6], ex[p+7]} = gsz[g*32+:32];
         {ex[p+8], ex[p+9], ex[p+10], ex[p+11]} = 32'h00000000;
         p = p + 12;
      end
      {ex[p], ex[p+1], ex[p+2], ex[p+3], ex[p+4], ex[p+5]} = 48'h000000000000;
      p = p + 6;
      {ex[47], ex[48]} = 16'(p - 53);
      {ex[23], ex[24]} = 16'(p - 29);
      {ex[6], ex[7]} = {4'h7, 12'(p - 8)};
   endtask : mk

   task automatic chk(input int b, input int lo, input int hi);
      for (int i = lo; i <= hi; i++)
         check(dsifr_sink_inst.got[b+i], {i == 187, i == 0, ex[i]}, "packet byte");
   endtask : chk

   task automatic judge(input int b, input logic [3:0] cc);
      mk(cc);
      chk(b, 0, 2);
      chk(b, 3, 3);
      chk(b, 4, 5);
      chk(b, 6, 7);
      chk(b, 8, 9);
      chk(b, 10, 12);
      chk(b, 13, 16);
      chk(b, 17, 20);
      chk(b, 21, 22);
      chk(b, 23, 24);
      chk(b, 25, 46);
      chk(b, 47, 50);
      chk(b, 51, 74);
      chk(b, 75, 80);
      chk(b, 81, 187);
   endtask : judge

   task automatic wait_bytes(input int n);
      for (int t = 0; t < 4000 && dsifr_sink_inst.got.size() < n; t++)
         @(posedge clk);
      #1;
      check({9'h000, dsifr_sink_inst.got.size() >= n}, 10'h001, "byte count");
   endtask : wait_bytes

   // busy must rise on the same edge that takes the start
   task automatic launch(input logic hold);
      dsifr_sink_inst.got.delete();
      start = 1'h1;
      @(posedge clk);
      #1;
      check({9'h000, busy}, 10'h001, "busy after start");
      start = hold;
   endtask : launch

   task automatic t_sample;
      {pid, tver, tidn, tupd} = {13'h00FF, 14'h0000, 15'h0000, 1'h0};
      gid = {32'h80000004, 32'h80000002};
      gsz = {32'h0000003D, 32'h0000002D};
      launch(1'h0);
      wait_bytes(188);
      judge(0, 4'h0);
      repeat (3) @(posedge clk);
      #1;
      check({9'h000, busy}, 10'h000, "busy after packet");
      check(10'(dsifr_sink_inst.got.size()), 10'd188, "no extra bytes");
      check(10'(dsifr_sink_inst.unverified), 10'h001, "unverified count");
      $display("test sample packet done");
   endtask : t_sample

   task automatic t_stall;
      slow = 1'h1;
      {pid, tver, tidn, tupd} = {13'h1FFF, 14'h2AAA, 15'h5555, 1'h1};
      gid = {32'h8000000A, 32'hFFFFFFFE};
      gsz = {32'h00001234, 32'hA5A55A5A};
      launch(1'h0);
      gid = 64'h0;
      wait_bytes(188);
      // expected ids are the ones latched at start, not the cleared source
      gid = {32'h8000000A, 32'hFFFFFFFE};
      judge(0, 4'h1);
      slow = 1'h0;
      $display("test stalled sink done");
   endtask : t_stall

   // start held high: back to back packets, continuity counter wraps
   task automatic t_wrap;
      {pid, tver, tidn, tupd} = {13'h1000, 14'h0001, 15'h0002, 1'h0};
      gid = {32'h80000006, 32'h80000008};
      launch(1'h1);
      wait_bytes(15 * 188 + 1);
      start = 1'h0;
      wait_bytes(16 * 188);
      repeat (4) @(posedge clk);
      #1;
      check(10'(dsifr_sink_inst.got.size() / 188), 10'h010, "packet count");
      for (int k = 0; k < 16; k++)
         judge(k * 188, 4'(k + 2));
      $display("test counter wrap done");
   endtask : t_wrap

   initial begin
      {arst_n, ce, start, slow, pid, tver, tidn, tupd} = {2'h1, 2'h0, 43'h0};
      {gid, gsz} = 128'h0;
      arst_n = 1'h0;
      repeat (6) @(posedge clk);
      #1;
      arst_n = 1'h1;
      t_sample;
      t_stall;
      t_wrap;
      give_verdict;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict;
   end
endmodule : dsifr_framer_bench
